// ---- core/pcma_cmp.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcma_cmp (
  // operands and verdict
  pcma_cmp_if.eval c
);
  // unsigned magnitude compare of the six operators
  function automatic logic cmp_eval(input logic [15:0] a, input logic [15:0] b,
                                    input pcma_pkg::pcma_cmp_t op);
    case (op)
      pcma_pkg::PCMA_CMP_LT: cmp_eval = a < b;
      pcma_pkg::PCMA_CMP_GT: cmp_eval = a > b;
      pcma_pkg::PCMA_CMP_EQ: cmp_eval = a == b;
      pcma_pkg::PCMA_CMP_LE: cmp_eval = a <= b;
      pcma_pkg::PCMA_CMP_GE: cmp_eval = a >= b;
      pcma_pkg::PCMA_CMP_NE: cmp_eval = a != b;
      default: cmp_eval = 1'b0;
    endcase
  endfunction

  assign c.holds = cmp_eval(c.lhs, c.rhs, c.op);
  // operands above the compare limit are flagged, not silently truncated
  assign c.too_big = (c.lhs > pcma_pkg::PCMA_CMP_MAX) ||
                     (c.rhs > pcma_pkg::PCMA_CMP_MAX);
endmodule // pcma_cmp
`default_nettype wire

// ---- core/pcma_top.sv ----
// Operation
// - compare supports less, greater, equal, less-equal, greater-equal, not-equal
// - true compare runs next line; false compare skips exactly one line
// - each operand is a register value or a constant, both evaluated
// - module read targets address 0 to 31
// - module read selects remote register index 0 to 255
// - returned value outside optional range stops program execution
// - returned value is written into the named controller register
// - flag set request sends flag 1..255 to module 1..31
// - flag clear request sends flag 1..255 to module 1..31
// - print sends register value to module cursor or register position
// - print destination 255 goes to host serial port instead
// - compare operands must not exceed 32767
// - all values are unsigned 16-bit integers
`timescale 1ns/1ps
`default_nettype none
module pcma_top (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  // statement from the program sequencer
  input wire logic stmt_valid,
  output logic stmt_ready,
  input wire pcma_pkg::pcma_op_t stmt_op,
  input wire pcma_pkg::pcma_cmp_t stmt_cmp,
  input wire logic lhs_is_reg,
  input wire logic [15:0] lhs_const,
  input wire logic rhs_is_reg,
  input wire logic [15:0] rhs_const,
  input wire logic [7:0] stmt_addr,
  input wire logic [7:0] stmt_index,
  input wire logic [8:0] stmt_reg,
  // second compare operand register, so both operands may be distinct registers
  input wire logic [8:0] rhs_reg,
  input wire logic range_en,
  input wire logic [15:0] range_lo,
  input wire logic [15:0] range_hi,
  // controller register file port
  output logic [8:0] rf_raddr_a,
  output logic [8:0] rf_raddr_b,
  input wire logic [15:0] rf_rdata_a,
  input wire logic [15:0] rf_rdata_b,
  output logic rf_we,
  output logic [8:0] rf_waddr,
  output logic [15:0] rf_wdata,
  // verdict to the sequencer
  output logic done,
  output logic skip_next,
  output logic halt,
  output logic [1:0] err_code,
  // module bus request and answer
  output logic bus_req,
  input wire logic bus_ack,
  output logic [1:0] bus_kind,
  output logic [4:0] bus_addr,
  output logic [7:0] bus_index,
  output logic [15:0] bus_wdata,
  input wire logic bus_rvalid,
  input wire logic [15:0] bus_rdata,
  // host serial port request
  output logic host_req,
  input wire logic host_ack,
  output logic [7:0] host_pos,
  output logic [15:0] host_data
);
  typedef enum logic [2:0] {
    PCMA_ST_IDLE = 3'b000,
    PCMA_ST_BUS = 3'b001,
    PCMA_ST_WAIT = 3'b010,
    PCMA_ST_HOST = 3'b011,
    PCMA_ST_DONE = 3'b100
  } pcma_st_t;

  pcma_st_t st_ff, nxt_st;
  logic done_ff, skip_ff, halt_ff;
  logic [1:0] err_ff;
  logic bus_req_ff, host_req_ff, rf_we_ff;
  logic [1:0] kind_ff;
  logic [4:0] baddr_ff;
  logic [7:0] bidx_ff, hpos_ff;
  logic [15:0] bdata_ff, hdata_ff, rf_wdata_ff, lo_ff, hi_ff;
  logic [8:0] rf_waddr_ff;
  logic rng_ff;

  // operand selection: register port or literal
  wire [15:0] lhs_val = lhs_is_reg ? rf_rdata_a : lhs_const;
  wire [15:0] rhs_val = rhs_is_reg ? rf_rdata_b : rhs_const;
  wire take = ce && stmt_valid && (st_ff == PCMA_ST_IDLE);
  // argument checks per statement kind
  wire read_ok = stmt_addr <= pcma_pkg::PCMA_MOD_ADDR_MAX;
  wire flag_ok = (stmt_addr >= pcma_pkg::PCMA_ADDR_MIN_FLAG) &&
                 (stmt_addr <= pcma_pkg::PCMA_MOD_ADDR_MAX) &&
                 (stmt_index >= pcma_pkg::PCMA_FLAG_MIN);
  wire to_host = stmt_addr == pcma_pkg::PCMA_HOST_ADDR;
  wire print_ok = to_host || (stmt_addr <= pcma_pkg::PCMA_MOD_ADDR_MAX);
  wire out_range = rng_ff && ((bus_rdata < lo_ff) || (bus_rdata > hi_ff));

  pcma_cmp_if cif ();
  assign cif.lhs = lhs_val;
  assign cif.rhs = rhs_val;
  assign cif.op = stmt_cmp;
  pcma_cmp u_cmp (
    .c(cif.eval)
  );

  // register file reads go straight from the statement fields
  assign rf_raddr_a = stmt_reg;
  assign rf_raddr_b = rhs_reg;
  // sequencer may present a new statement only while idle
  assign stmt_ready = ce && (st_ff == PCMA_ST_IDLE);
  assign done = done_ff;
  assign skip_next = skip_ff;
  assign halt = halt_ff;
  assign err_code = err_ff;
  assign bus_req = bus_req_ff;
  assign bus_kind = kind_ff;
  assign bus_addr = baddr_ff;
  assign bus_index = bidx_ff;
  assign bus_wdata = bdata_ff;
  assign host_req = host_req_ff;
  assign host_pos = hpos_ff;
  assign host_data = hdata_ff;
  assign rf_we = rf_we_ff;
  assign rf_waddr = rf_waddr_ff;
  assign rf_wdata = rf_wdata_ff;

  // next state: bus and host accesses reach done only after the answer, so lines never overlap
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      PCMA_ST_IDLE: begin
        if (stmt_valid) begin
          case (stmt_op)
            pcma_pkg::PCMA_OP_READ: nxt_st = read_ok ? PCMA_ST_BUS : PCMA_ST_DONE;
            pcma_pkg::PCMA_OP_PRINT: nxt_st = !print_ok ? PCMA_ST_DONE :
                                      (to_host ? PCMA_ST_HOST : PCMA_ST_BUS);
            pcma_pkg::PCMA_OP_FSET, pcma_pkg::PCMA_OP_FCLR:
              nxt_st = flag_ok ? PCMA_ST_BUS : PCMA_ST_DONE;
            default: nxt_st = PCMA_ST_DONE;
          endcase
        end
      end
      PCMA_ST_BUS: if (bus_ack) nxt_st = (kind_ff == pcma_pkg::PCMA_REQ_READ) ?
                                        PCMA_ST_WAIT : PCMA_ST_DONE;
      PCMA_ST_WAIT: if (bus_rvalid) nxt_st = PCMA_ST_DONE;
      PCMA_ST_HOST: if (host_ack) nxt_st = PCMA_ST_DONE;
      PCMA_ST_DONE: nxt_st = PCMA_ST_IDLE;
      default: nxt_st = PCMA_ST_IDLE;
    endcase
  end

  // state register; everything freezes while ce is low
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_ff <= PCMA_ST_IDLE;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // request capture on statement accept
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      kind_ff <= pcma_pkg::PCMA_REQ_READ;
      baddr_ff <= 5'h00;
      bidx_ff <= 8'h00;
      bdata_ff <= pcma_pkg::PCMA_RST_DATA;
      hpos_ff <= 8'h00;
      hdata_ff <= pcma_pkg::PCMA_RST_DATA;
      rf_waddr_ff <= 9'h000;
      rng_ff <= 1'b0;
      lo_ff <= pcma_pkg::PCMA_RST_DATA;
      hi_ff <= pcma_pkg::PCMA_RST_DATA;
    end else if (take) begin
      baddr_ff <= stmt_addr[4:0];
      bidx_ff <= stmt_index;
      bdata_ff <= lhs_val;
      hpos_ff <= stmt_index;
      hdata_ff <= lhs_val;
      rf_waddr_ff <= stmt_reg;
      rng_ff <= range_en;
      lo_ff <= range_lo;
      hi_ff <= range_hi;
      case (stmt_op)
        pcma_pkg::PCMA_OP_PRINT: kind_ff <= pcma_pkg::PCMA_REQ_WRITE;
        pcma_pkg::PCMA_OP_FSET: kind_ff <= pcma_pkg::PCMA_REQ_FSET;
        pcma_pkg::PCMA_OP_FCLR: kind_ff <= pcma_pkg::PCMA_REQ_FCLR;
        default: kind_ff <= pcma_pkg::PCMA_REQ_READ;
      endcase
    end
  end

  // request strobes held until acknowledged
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bus_req_ff <= 1'b0;
      host_req_ff <= 1'b0;
    end else if (ce) begin
      bus_req_ff <= (nxt_st == PCMA_ST_BUS);
      host_req_ff <= (nxt_st == PCMA_ST_HOST);
    end
  end

  // read data lands in the target register unless it fails the range check
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rf_we_ff <= 1'b0;
      rf_wdata_ff <= pcma_pkg::PCMA_RST_DATA;
    end else if (ce) begin
      rf_we_ff <= (st_ff == PCMA_ST_WAIT) && bus_rvalid && !out_range;
      if ((st_ff == PCMA_ST_WAIT) && bus_rvalid) rf_wdata_ff <= bus_rdata;
    end
  end

  // verdict pulses; skip reflects a failed compare, halt a range, operand or argument fault
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      done_ff <= 1'b0;
      skip_ff <= 1'b0;
      halt_ff <= 1'b0;
      err_ff <= pcma_pkg::PCMA_ERR_NONE;
    end else if (ce) begin
      done_ff <= (nxt_st == PCMA_ST_DONE);
      skip_ff <= 1'b0;
      halt_ff <= 1'b0;
      err_ff <= pcma_pkg::PCMA_ERR_NONE;
      if (take && stmt_op == pcma_pkg::PCMA_OP_CMP) begin
        if (cif.too_big) begin
          halt_ff <= 1'b1;
          err_ff <= pcma_pkg::PCMA_ERR_OPND;
        end else begin
          skip_ff <= !cif.holds;
        end
      end else if (take && nxt_st == PCMA_ST_DONE && stmt_op != pcma_pkg::PCMA_OP_NONE) begin
        halt_ff <= 1'b1;
        err_ff <= pcma_pkg::PCMA_ERR_ARG;
      end else if (st_ff == PCMA_ST_WAIT && bus_rvalid && out_range) begin
        halt_ff <= 1'b1;
        err_ff <= pcma_pkg::PCMA_ERR_RANGE;
      end
    end
  end
endmodule // pcma_top
`default_nettype wire

// ---- inc/pcma_cmp_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// carries one comparison between the interpreter and its comparator
interface pcma_cmp_if;
  logic [15:0] lhs;
  logic [15:0] rhs;
  pcma_pkg::pcma_cmp_t op;
  logic holds;
  logic too_big;
  modport req (output lhs, output rhs, output op, input holds, input too_big);
  modport eval (input lhs, input rhs, input op, output holds, output too_big);
endinterface
`default_nettype wire

// ---- inc/pcma_pkg.sv ----
`default_nettype none
package pcma_pkg;
  // statement kinds presented by the program sequencer
  typedef enum logic [2:0] {
    PCMA_OP_NONE  = 3'b000,
    PCMA_OP_CMP   = 3'b001,
    PCMA_OP_READ  = 3'b010,
    PCMA_OP_PRINT = 3'b011,
    PCMA_OP_FSET  = 3'b100,
    PCMA_OP_FCLR  = 3'b101
  } pcma_op_t;

  // comparison operators
  typedef enum logic [2:0] {
    PCMA_CMP_LT = 3'b000,
    PCMA_CMP_GT = 3'b001,
    PCMA_CMP_EQ = 3'b010,
    PCMA_CMP_LE = 3'b011,
    PCMA_CMP_GE = 3'b100,
    PCMA_CMP_NE = 3'b101
  } pcma_cmp_t;

  // request codes placed on the module bus
  typedef enum logic [1:0] {
    PCMA_REQ_READ  = 2'b00,
    PCMA_REQ_WRITE = 2'b01,
    PCMA_REQ_FSET  = 2'b10,
    PCMA_REQ_FCLR  = 2'b11
  } pcma_req_t;

  // error codes
  typedef enum logic [1:0] {
    PCMA_ERR_NONE  = 2'b00,
    PCMA_ERR_RANGE = 2'b01,
    PCMA_ERR_OPND  = 2'b10,
    PCMA_ERR_ARG   = 2'b11
  } pcma_err_t;

  localparam int PCMA_DATA_W = 16;
  localparam int PCMA_ADDR_W = 8;
  localparam logic [15:0] PCMA_CMP_MAX = 16'h7fff;
  localparam logic [7:0] PCMA_MOD_ADDR_MAX = 8'h1f;
  localparam logic [7:0] PCMA_FLAG_MIN = 8'h01;
  localparam logic [7:0] PCMA_ADDR_MIN_FLAG = 8'h01;
  localparam logic [7:0] PCMA_HOST_ADDR = 8'hff;
  localparam logic [15:0] PCMA_RST_DATA = 16'h0000;
endpackage
`default_nettype wire

// ---- sim/pcma_mod_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcma_mod_model (
  // clock, reset and pacing
  input wire logic clock,
  input wire logic nrst,
  input wire logic slow,
  // module bus
  input wire logic bus_req,
  input wire logic [1:0] bus_kind,
  input wire logic [4:0] bus_addr,
  input wire logic [7:0] bus_index,
  output logic bus_ack,
  output logic bus_rvalid,
  output logic [15:0] bus_rdata,
  // host port
  input wire logic host_req,
  output logic host_ack
);
  logic [1:0] k;
  logic [15:0] v;
  // every address is populated; a read returns a value built from address and index
  initial begin
    bus_ack = 1'b0;
    bus_rvalid = 1'b0;
    bus_rdata = 16'h0000;
    forever begin
      @(posedge clock);
      if (nrst && bus_req) begin
        repeat (slow ? 3 : 0) @(posedge clock);
        bus_ack <= 1'b1;
        k = bus_kind;
        v = {3'h5, bus_addr, bus_index};
        @(posedge clock);
        bus_ack <= 1'b0;
        if (k == pcma_pkg::PCMA_REQ_READ) begin
          repeat (slow ? 4 : 1) @(posedge clock);
          bus_rvalid <= 1'b1;
          bus_rdata <= v;
          @(posedge clock);
          bus_rvalid <= 1'b0;
          bus_rdata <= ~v; // stale data must never look valid
        end
      end
    end
  end
  // host answers one cycle after a request
  always @(posedge clock or negedge nrst) begin
    if (!nrst) host_ack <= 1'b0;
    else host_ack <= host_req && !host_ack;
  end
endmodule // pcma_mod_model
`default_nettype wire

// ---- sim/pcma_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcma_props (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // statement and verdict
  input wire logic stmt_valid,
  input wire logic stmt_ready,
  input wire pcma_pkg::pcma_op_t stmt_op,
  input wire logic done,
  input wire logic skip_next,
  input wire logic halt,
  input wire logic [1:0] err_code,
  input wire logic rf_we,
  // module bus and host port
  input wire logic bus_req,
  input wire logic bus_ack,
  input wire logic [1:0] bus_kind,
  input wire logic [4:0] bus_addr,
  input wire logic bus_rvalid,
  input wire logic host_req,
  input wire logic host_ack
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // a statement is taken when offered while ready
  wire take = stmt_valid && stmt_ready;
  a_cmp_answer:
    assert property (take && stmt_op == pcma_pkg::PCMA_OP_CMP |=> done || halt)
    else $error("compare not answered");
  a_skip_done:
    assert property (skip_next |-> done) else $error("skip without done");
  a_req_holds:
    assert property (bus_req && !bus_ack |=> bus_req) else $error("bus request dropped");
  a_req_drops:
    assert property (bus_req && bus_ack |=> !bus_req) else $error("bus request stuck");
  a_we_after_data:
    assert property (rf_we |-> $past(bus_rvalid) && done) else $error("write without data");
  a_halt_code:
    assert property (halt |-> err_code != 2'h0 && !rf_we) else $error("bad halt");
  a_flag_addr:
    assert property (bus_req && bus_kind[1] |-> bus_addr != 5'h00) else $error("flag addr 0");
  a_busy_refuse:
    assert property (bus_req || host_req |-> !stmt_ready) else $error("ready while busy");
  a_host_holds:
    assert property (host_req && !host_ack |=> host_req) else $error("host request dropped");
  // main scenarios reached
  c_skip: cover property (skip_next);
  c_read: cover property (rf_we);
  c_host: cover property (host_req && host_ack);
  c_range_halt: cover property (halt && err_code == 2'h1);
endmodule // pcma_props
bind pcma_top pcma_props u_props (.*);
`default_nettype wire

// ---- sim/tb_program_compare_and_module_access.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_program_compare_and_module_access;
  logic clock = 1'b0;
  logic nrst, ce, stmt_valid, stmt_ready, lhs_is_reg, rhs_is_reg, range_en, rf_we, done;
  logic skip_next, halt, bus_req, bus_ack, bus_rvalid, host_req, host_ack, slow, bad;
  logic r_skip, r_halt, r_we;
  pcma_pkg::pcma_op_t stmt_op;
  pcma_pkg::pcma_cmp_t stmt_cmp;
  logic [15:0] lhs_const, rhs_const, range_lo, range_hi, rf_rdata_a, rf_rdata_b, rf_wdata;
  logic [15:0] bus_wdata, bus_rdata, host_data, r_wd, c_wd, c_hd, la, lb, v;
  logic [8:0] stmt_reg, rhs_reg, rf_raddr_a, rf_raddr_b, rf_waddr, r_wa;
  logic [7:0] stmt_addr, stmt_index, bus_index, host_pos, c_i, c_hp, x;
  logic [4:0] bus_addr, c_a, a;
  logic [1:0] err_code, bus_kind, r_err, c_k;
  int failures = 0;
  int total_checks = 0;
  int i;
  pcma_top dut_u (.*);
  pcma_mod_model u_mod (.*);
  always #25 clock = ~clock;
  // record what reached the bus and the host port
  always @(posedge clock) begin
    if (bus_req && bus_ack) {c_k, c_a, c_i, c_wd} <= {bus_kind, bus_addr, bus_index, bus_wdata};
    if (host_req && host_ack) {c_hp, c_hd} <= {host_pos, host_data};
  end
  function automatic logic holds(input int c, input logic [15:0] p, input logic [15:0] q);
    case (c)
      0: return p < q;
      1: return p > q;
      2: return p == q;
      3: return p <= q;
      4: return p >= q;
      default: return p != q;
    endcase
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // offer one statement at a falling edge and collect its verdict
  task automatic run(input int op, input logic [7:0] ad, input logic [7:0] ix);
    int n;
    n = 0;
    stmt_op = pcma_pkg::pcma_op_t'(op);
    stmt_addr = ad;
    stmt_index = ix;
    stmt_valid = 1'b1;
    while (!stmt_ready && n < 50) begin @(negedge clock); n++; end
    @(negedge clock);
    stmt_valid = 1'b0;
    while (!(done || halt) && n < 100) begin @(negedge clock); n++; end
    {r_skip, r_halt, r_err, r_we, r_wd, r_wa} = {skip_next, halt, err_code, rf_we, rf_wdata, rf_waddr};
    if (n >= 100) failures++;
    @(negedge clock);
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // watchdog well beyond the expected few hundred cycles
  initial begin
    #2000000;
    failures++;
    stop_test();
  end
  initial begin
    {nrst, ce, stmt_valid, lhs_is_reg, rhs_is_reg, range_en, slow} = 7'h20;
    stmt_op = pcma_pkg::PCMA_OP_NONE;
    stmt_cmp = pcma_pkg::PCMA_CMP_LT;
    {stmt_addr, stmt_index, stmt_reg, rhs_reg} = '0;
    {lhs_const, rhs_const, range_lo, range_hi, rf_rdata_a, rf_rdata_b} = '0;
    void'($urandom(32'h3c3d));
    repeat (4) @(negedge clock);
    nrst = 1'b1;
    ce = 1'b0;
    @(negedge clock);
    chk(16'(stmt_ready), 16'h0000);
    ce = 1'b1;
    // every operator, register or constant operands, 7fff and equal corners
    for (i = 0; i < 50; i++) begin
      stmt_cmp = pcma_pkg::pcma_cmp_t'(i % 6);
      {lhs_is_reg, rhs_is_reg} = 2'(i / 6);
      la = i < 6 ? 16'h7fff : 16'($urandom % 32768);
      lb = i % 3 == 0 ? la : 16'($urandom % 32768);
      stmt_reg = 9'($urandom);
      rhs_reg = 9'($urandom);
      {rf_rdata_a, lhs_const} = {la ^ {16{!lhs_is_reg}}, la ^ {16{lhs_is_reg}}};
      {rf_rdata_b, rhs_const} = {lb ^ {16{!rhs_is_reg}}, lb ^ {16{rhs_is_reg}}};
      run(1, 8'h00, 8'h00);
      chk(16'({r_halt, r_skip}), 16'(!holds(i % 6, la, lb)));
      chk(16'(rf_raddr_a), 16'(stmt_reg));
      chk(16'(rf_raddr_b), 16'(rhs_reg));
    end
    lhs_is_reg = 1'b0;
    lhs_const = 16'h8000;
    run(1, 8'h00, 8'h00);
    chk(16'({r_halt, r_err}), 16'h0006);
    // empty statement finishes quietly; a read above address 31 is refused
    run(0, 8'h00, 8'h00);
    chk(16'({r_halt, r_err}), 16'h0000);
    run(2, 8'h20, 8'h00);
    chk(16'({r_halt, r_err}), 16'h0007);
    // reads, fast and slow, with and without a range
    for (i = 0; i < 12; i++) begin
      slow = i[0];
      range_en = i[1];
      a = i < 2 ? 5'(i * 31) : 5'($urandom);
      x = 8'($urandom);
      stmt_reg = 9'($urandom);
      v = {3'h5, a, x};
      range_lo = v + 16'(i[2]);
      range_hi = i[3] ? v - 16'h0001 : 16'hffff;
      bad = i[1] & (i[2] | i[3]);
      run(2, 8'(a), x);
      chk(16'({r_halt, r_we, r_err}), bad ? 16'h0009 : 16'h0004);
      chk(16'({c_k, c_a, c_i}), 16'({2'h0, a, x}));
      if (!bad) chk(r_wd, v);
      if (!bad) chk(16'(r_wa), 16'(stmt_reg));
    end
    // flag set and clear, including refused address and flag zero
    for (i = 0; i < 8; i++) begin
      a = i == 2 ? 5'h00 : i == 3 ? 5'h1f : 5'($urandom % 31 + 1);
      x = i == 4 ? 8'h00 : i == 5 ? 8'hff : 8'($urandom % 255 + 1);
      bad = a == 5'h00 || x == 8'h00 || i == 6;
      run(4 + i % 2, i == 6 ? 8'h20 : 8'(a), x);
      chk(16'({r_halt, r_err}), bad ? 16'h0007 : 16'h0000);
      if (!bad) chk(16'({c_k, c_a, c_i}), 16'({2'(2 + i % 2), a, x}));
    end
    // print to a module, to the host, and to a refused address
    lhs_is_reg = 1'b1;
    for (i = 0; i < 3; i++) begin
      la = 16'($urandom);
      rf_rdata_a = la;
      x = 8'($urandom);
      run(3, i == 0 ? 8'h02 : i == 1 ? 8'hff : 8'h28, x);
      chk(16'({r_halt, r_err}), i == 2 ? 16'h0007 : 16'h0000);
      if (i == 0) chk(c_wd, la);
      if (i == 0) chk(16'({c_k, c_a, c_i}), 16'({2'h1, 5'h02, x}));
      if (i == 1) chk(c_hd, la);
      if (i == 1) chk(16'(c_hp), 16'(x));
    end
    stop_test();
  end
endmodule // tb_program_compare_and_module_access
`default_nettype wire
